/* File: coil_voltage_capture_regs.sv */
`timescale 1ns/100ps
// Operation
// R1 - store average when phase counter equals 16
// R2 - store average when phase counter equals 32
// R3 - unsigned 10-bit code, full scale 28 V
// R4 - quarter-turn register 0x0A, value bits 10:1
// R5 - half-turn register 0x0B, same layout
// R6 - bit 0 carries serial frame parity
module coil_voltage_capture_regs
  import coil_voltage_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [coil_voltage_pkg::PHASE_W-1:0] PHASE_COUNT,
  input wire logic RESULT_VALID,
  input wire logic [coil_voltage_pkg::CODE_W-1:0] RESULT_CODE,
  input wire logic RD_EN,
  input wire logic [coil_voltage_pkg::ADDR_W-1:0] RD_ADDR,
  input wire logic FRAME_PARITY,
  output logic [coil_voltage_pkg::REG_W-1:0] RD_DATA,
  output logic RD_VALID
);

  import coil_voltage_pkg::*;

  localparam int SLOTS = 2;
  localparam logic [PHASE_W-1:0] SLOT_PHASE [SLOTS] = '{PHASE_QUARTER, PHASE_HALF};
  localparam logic [ADDR_W-1:0] SLOT_ADDR [SLOTS] = '{ADDR_QUARTER, ADDR_HALF};

  logic [CODE_W-1:0] slot_value [SLOTS];
  logic [REG_W-1:0] rd_data_reg;
  logic [REG_W-1:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////
  // capture slots

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : slot
      coil_voltage_slot #(
        .MATCH_PHASE(SLOT_PHASE[g])
      ) u_slot (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .phase(PHASE_COUNT),
        .result_valid(RESULT_VALID),
        .result_code(RESULT_CODE), // R1 R2 R3
        .value(slot_value[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read port

  // the frame a slot presents: upper bits zero, code, then parity
  function automatic logic [REG_W-1:0] frame(input logic [CODE_W-1:0] code, input logic par);
    logic [REG_W-1:0] f;
    f = FRAME_RESET;
    f[CODE_MSB:CODE_LSB] = code;
    f[PARITY_POS] = par;
    return f;
  endfunction

  // one address compare shared by the read mux and its checks
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input int i);
    logic hit;
    hit = 1'b0;
    if (a == SLOT_ADDR[i])
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  always_comb
  begin
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    mapped = 1'b0;
    if (RD_EN)
    begin
      rd_valid_next = 1'b1;
      // unmapped addresses answer all zero, parity included
      rd_data_next = FRAME_RESET;
      for (int i = 0; i < SLOTS; i++)
      begin
        if (addr_hit(RD_ADDR, i))
        begin
          mapped = 1'b1;
          rd_data_next = frame(slot_value[i], FRAME_PARITY); // R4 R5 R6
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      rd_data_reg <= FRAME_RESET;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign RD_VALID = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_quarter_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R1
    RESULT_VALID && PHASE_COUNT == 6'h10 |=> slot_value[0] == $past(RESULT_CODE))
    else $error("quarter-turn value not captured at phase 16");

  a_half_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R2
    RESULT_VALID && PHASE_COUNT == 6'h20 |=> slot_value[1] == $past(RESULT_CODE))
    else $error("half-turn value not captured at phase 32");

  a_quarter_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R1
    !(RESULT_VALID && PHASE_COUNT == 6'h10) |=> $stable(slot_value[0]))
    else $error("quarter-turn value changed off its step");

  a_half_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R2
    !(RESULT_VALID && PHASE_COUNT == 6'h20) |=> $stable(slot_value[1]))
    else $error("half-turn value changed off its step");

  a_upper_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R3
    RD_VALID |-> RD_DATA[15:11] == 5'h00)
    else $error("reserved upper bits not zero");

  a_quarter_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    RD_EN && RD_ADDR == 5'h0A |=> RD_VALID && RD_DATA[10:1] == $past(slot_value[0]))
    else $error("quarter-turn read returned wrong code");

  a_half_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R5
    RD_EN && RD_ADDR == 5'h0B |=> RD_VALID && RD_DATA[10:1] == $past(slot_value[1]))
    else $error("half-turn read returned wrong code");

  a_parity_bit: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R6
    RD_EN && mapped |=> RD_DATA[0] == $past(FRAME_PARITY))
    else $error("parity bit not carried in bit 0");

  a_reset_zero: assert property (@(posedge CLK_SYS) // R4
    !RST_B |=> slot_value[0] == 10'h000 && slot_value[1] == 10'h000 && !RD_VALID)
    else $error("values not zero after reset");

  // read handshake: one answer per request, data held between reads
  a_read_answer: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    RD_EN |=> RD_VALID)
    else $error("read request not answered");

  a_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    !RD_EN |=> !RD_VALID)
    else $error("valid raised without a request");

  a_data_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    !RD_EN |=> $stable(RD_DATA))
    else $error("read data changed between reads");

  a_mapped_decode: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    mapped == (RD_EN && (addr_hit(RD_ADDR, 0) || addr_hit(RD_ADDR, 1))))
    else $error("address decode disagrees");

  a_unmapped_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    RD_EN && !addr_hit(RD_ADDR, 0) && !addr_hit(RD_ADDR, 1) |=> RD_DATA == 16'h0000)
    else $error("unmapped read not zero");

  a_unmapped_parity: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R6
    RD_EN && !mapped |=> RD_DATA[0] == 1'b0)
    else $error("unmapped read carried parity");

  a_quarter_upper: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    RD_EN && RD_ADDR == ADDR_QUARTER |=> RD_DATA[15:11] == 5'h00)
    else $error("quarter-turn upper bits not zero");

  a_half_upper: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R5
    RD_EN && RD_ADDR == ADDR_HALF |=> RD_DATA[15:11] == 5'h00)
    else $error("half-turn upper bits not zero");

  a_quarter_parity: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R6
    RD_EN && RD_ADDR == ADDR_QUARTER |=> RD_DATA[0] == $past(FRAME_PARITY))
    else $error("quarter-turn parity bit wrong");

  a_half_parity: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R6
    RD_EN && RD_ADDR == ADDR_HALF |=> RD_DATA[0] == $past(FRAME_PARITY))
    else $error("half-turn parity bit wrong");

  // a read racing a capture of its own slot sees the old code
  a_quarter_old: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R4
    RD_EN && RD_ADDR == ADDR_QUARTER && RESULT_VALID && PHASE_COUNT == PHASE_QUARTER
    |=> RD_DATA[10:1] == $past(slot_value[0]))
    else $error("quarter-turn racing read not old code");

  a_half_old: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R5
    RD_EN && RD_ADDR == ADDR_HALF && RESULT_VALID && PHASE_COUNT == PHASE_HALF
    |=> RD_DATA[10:1] == $past(slot_value[1]))
    else $error("half-turn racing read not old code");

  a_reset_frame: assert property (@(posedge CLK_SYS) // R4
    !RST_B |=> RD_DATA == 16'h0000)
    else $error("read frame not zero after reset");

  // captures of one slot must leave the other alone
  a_cross_quarter: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R1
    RESULT_VALID && PHASE_COUNT == PHASE_HALF |=> $stable(slot_value[0]))
    else $error("half-turn capture disturbed quarter-turn value");

  a_cross_half: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R2
    RESULT_VALID && PHASE_COUNT == PHASE_QUARTER |=> $stable(slot_value[1]))
    else $error("quarter-turn capture disturbed half-turn value");

  a_quarter_full: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R3
    RESULT_VALID && PHASE_COUNT == PHASE_QUARTER && RESULT_CODE == CODE_FULL_SCALE
    |=> slot_value[0] == 10'h3FF)
    else $error("quarter-turn full scale code lost");

  a_half_full: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // R3
    RESULT_VALID && PHASE_COUNT == PHASE_HALF && RESULT_CODE == CODE_FULL_SCALE
    |=> slot_value[1] == 10'h3FF)
    else $error("half-turn full scale code lost");

endmodule

/* File: coil_voltage_pkg.sv */
package coil_voltage_pkg;

  // register frame
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_QUARTER = 5'h0A;
  localparam logic [ADDR_W-1:0] ADDR_HALF = 5'h0B;

  // field layout inside the frame
  localparam int CODE_W = 10;
  localparam int CODE_LSB = 1;
  localparam int CODE_MSB = CODE_LSB + CODE_W - 1;
  localparam int PARITY_POS = 0;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
  localparam logic [REG_W-1:0] FRAME_RESET = 16'h0000;

  // phase counter positions of the captured micro-steps
  localparam int PHASE_W = 6;
  localparam logic [PHASE_W-1:0] PHASE_QUARTER = 6'h10;
  localparam logic [PHASE_W-1:0] PHASE_HALF = 6'h20;

  // full-scale code stands for the top of the supply operating range
  localparam int SUPPLY_FULL_SCALE_MV = 28000;
  localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 10'h3FF;

endpackage

/* File: coil_voltage_slot.sv */
`timescale 1ns/100ps
module coil_voltage_slot
  import coil_voltage_pkg::*;
#(
  parameter logic [PHASE_W-1:0] MATCH_PHASE = PHASE_QUARTER
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [PHASE_W-1:0] phase,
  input wire logic result_valid,
  input wire logic [CODE_W-1:0] result_code,
  output logic [CODE_W-1:0] value
);

  logic [CODE_W-1:0] value_reg;
  logic [CODE_W-1:0] value_next;

  // only the averaged result finishing on the matching step is kept;
  // other steps leave the last capture standing for the host
  always_comb
  begin
    value_next = value_reg;
    if (result_valid && (phase == MATCH_PHASE))
    begin
      value_next = result_code;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      value_reg <= CODE_RESET;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

/* File: serial_host.sv */
`timescale 1ns/100ps
module serial_host
(
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [coil_voltage_pkg::REG_W-1:0] rd_data,
  output logic rd_en,
  output logic [coil_voltage_pkg::ADDR_W-1:0] rd_addr,
  output logic frame_parity
);
  import coil_voltage_pkg::*;
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 5'h00;
    frame_parity = 1'b0;
  end
  // idle lines flip so a stale value never passes
  task automatic read(input logic [ADDR_W-1:0] a, input logic p, output logic [REG_W-1:0] d, output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    frame_parity = p;
    @(negedge clk);
    v = rd_valid;
    d = rd_data;
    rd_en = 1'b0;
    rd_addr = ~a;
    frame_parity = ~p;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import coil_voltage_pkg::*;
  logic CLK_SYS, RST_B, RESULT_VALID, RD_EN, FRAME_PARITY, RD_VALID;
  logic [PHASE_W-1:0] PHASE_COUNT;
  logic [CODE_W-1:0] RESULT_CODE, q_exp, h_exp;
  logic [ADDR_W-1:0] RD_ADDR;
  logic [REG_W-1:0] RD_DATA;
  int bad_count, checked;
  coil_voltage_capture_regs uut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PHASE_COUNT(PHASE_COUNT),
    .RESULT_VALID(RESULT_VALID), .RESULT_CODE(RESULT_CODE), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR),
    .FRAME_PARITY(FRAME_PARITY), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID));
  serial_host host (.clk(CLK_SYS), .rd_valid(RD_VALID), .rd_data(RD_DATA), .rd_en(RD_EN),
    .rd_addr(RD_ADDR), .frame_parity(FRAME_PARITY));
  function automatic logic [REG_W-1:0] frame(input logic [ADDR_W-1:0] a, input logic p);
    if (a == ADDR_QUARTER) return {5'h00, q_exp, p};
    if (a == ADDR_HALF) return {5'h00, h_exp, p};
    return FRAME_RESET;
  endfunction
  task automatic rd(input logic [ADDR_W-1:0] a, input logic p);
    logic [REG_W-1:0] d;
    logic v;
    host.read(a, p, d, v);
    checked++;
    if (v !== 1'b1 || d !== frame(a, p))
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, d, frame(a, p));
    end
  endtask
  // model updates after the edge, reads always follow later
  task automatic cap(input logic [PHASE_W-1:0] ph, input logic v, input logic [CODE_W-1:0] c);
    @(negedge CLK_SYS);
    PHASE_COUNT = ph;
    RESULT_VALID = v;
    RESULT_CODE = c;
    @(negedge CLK_SYS);
    RESULT_VALID = 1'b0;
    RESULT_CODE = ~c;
    if (v && ph == PHASE_QUARTER) q_exp = c;
    if (v && ph == PHASE_HALF) h_exp = c;
  endtask
  task automatic finish_test;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    int s;
    bad_count = 0;
    checked = 0;
    q_exp = CODE_RESET;
    h_exp = CODE_RESET;
    RST_B = 1'b0;
    PHASE_COUNT = 6'h00;
    RESULT_VALID = 1'b0;
    RESULT_CODE = 10'h000;
    repeat (16) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST_B = 1'b1;
    void'($urandom(88663));
    rd(ADDR_QUARTER, 1'b1);
    rd(ADDR_HALF, 1'b0);
    $display("test defaults done");
    cap(PHASE_QUARTER, 1'b1, CODE_FULL_SCALE);
    cap(PHASE_HALF, 1'b1, CODE_FULL_SCALE);
    rd(ADDR_QUARTER, 1'b0);
    rd(ADDR_HALF, 1'b1);
    cap(PHASE_QUARTER + 6'h01, 1'b1, 10'h155);
    cap(PHASE_HALF - 6'h01, 1'b1, 10'h2AA);
    rd(ADDR_QUARTER, 1'b1);
    rd(ADDR_HALF, 1'b0);
    $display("test full scale done");
    repeat (300)
    begin
      s = $urandom % 3;
      cap(s == 0 ? PHASE_QUARTER : s == 1 ? PHASE_HALF : 6'($urandom), 1'($urandom), 10'($urandom));
      s = $urandom % 3;
      rd(s == 0 ? ADDR_QUARTER : s == 1 ? ADDR_HALF : 5'($urandom), 1'($urandom));
    end
    $display("test random done");
    finish_test();
  end
endmodule
